// >>> verilog/crps_pkg.sv
package crps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the AHB-Lite slave
  localparam logic [7:0] ADDR_PWR_SAVE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // Power-save control fields
  localparam int unsigned LOW_POWER_ENABLE_BIT = 15;
  localparam int unsigned DIV_SEL_LSB = 0;
  localparam int unsigned DIV_SEL_W = 2;
  localparam logic [15:0] PWR_SAVE_RESET = 16'h0000;

  // Status register fields
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_RESET_BIT = 4;
  localparam int unsigned STAT_PEND_BIT = 8;
  localparam int unsigned STAT_ACT_SEL_LSB = 12;
  localparam int unsigned STAT_ACT_EN_BIT = 15;

  ////////////////////////////////////////////////////////////////////////////
  // Divisor select encodings and half-period lengths in oscillator falls
  localparam logic [1:0] SEL_DIV1 = 2'h0;
  localparam logic [1:0] SEL_DIV4 = 2'h1;
  localparam logic [1:0] SEL_DIV8 = 2'h2;
  localparam logic [1:0] SEL_DIV16 = 2'h3;
  localparam int unsigned HALF_W = 5;
  localparam logic [HALF_W-1:0] HALF_DIV1 = 5'h01;
  localparam logic [HALF_W-1:0] HALF_DIV4 = 5'h04;
  localparam logic [HALF_W-1:0] HALF_DIV8 = 5'h08;
  localparam logic [HALF_W-1:0] HALF_DIV16 = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and clock timing, in oscillator falls or clock_out edges
  localparam int unsigned COLD_PIN_RESET_OSC = 28;
  localparam logic [1:0] SKIP_LOAD = 2'h1;
  localparam logic [1:0] RELEASE_FALLS = 2'h2;
  localparam logic [3:0] BUS_START_HALVES = 4'hd;
  localparam logic [1:0] APPLY_FALLS = 2'h3;

  // AHB-Lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ASSERT = 2'b01,
    ST_HELD = 2'b11,
    ST_RELEASE = 2'b10
  } crps_rst_state_t;

  // Half period of clock_out in oscillator falls for an applied setting
  function automatic logic [HALF_W-1:0] div_half(input logic en, input logic [1:0] sel);
    logic [HALF_W-1:0] h;
    h = HALF_DIV1;
    if (en) begin
      case (sel)
        SEL_DIV4: h = HALF_DIV4;
        SEL_DIV8: h = HALF_DIV8;
        SEL_DIV16: h = HALF_DIV16;
        default: h = HALF_DIV1;
      endcase
    end
    return h;
  endfunction

endpackage

// >>> verilog/crps_div.sv
`timescale 1ns/100ps
module crps_div #(
  parameter int unsigned CNT_W = 5
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic osc_fall_in,
  input wire logic restart_in,
  input wire logic [CNT_W-1:0] half_len_in,
  output logic toggle_out
);

  logic [CNT_W-1:0] cnt_q;

  // Toggle on the last oscillator fall of a half period
  assign toggle_out = osc_fall_in && (cnt_q == CNT_W'(half_len_in - 1'b1));

  // Restart clears the count so the next half period is whole, no runt
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cnt_q <= '0;
    end else if (restart_in || toggle_out) begin
      cnt_q <= '0;
    end else if (osc_fall_in) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule

// >>> verilog/crps_top.sv
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module crps_top #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic OSC_IN,
  input wire logic EXTERNAL_INIT_N_IN,
  input wire logic HOLD_REQ_IN,
  input wire logic NMI_IN,
  input wire logic IRQ_TO_CORE_IN,
  input wire logic HSEL_IN,
  input wire logic [ADDR_W-1:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic CLOCK_OUT,
  output logic SYS_RESET_OUT,
  output logic PHASE_REALIGN_PULSE_OUT,
  output logic BUS_GRANT_ACK_OUT,
  output logic PREFETCH_EN_OUT,
  output logic BUS_START_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  crps_pkg::crps_rst_state_t st_q;
  logic osc_q;
  logic osc_fall;
  logic clk_q;
  logic clk_d;
  logic clk_fall;
  logic clk_edge;
  logic toggle;
  logic div_restart;
  logic release_force;
  logic [1:0] skip_q;
  logic [1:0] rel_q;
  logic [3:0] bus_cnt_q;
  logic bus_start_q;
  logic sys_reset_q;
  logic realign_q;
  logic ps_en_q;
  logic [1:0] ps_sel_q;
  logic act_en_q;
  logic [1:0] act_sel_q;
  logic [1:0] pend_q;
  logic apply_now;
  logic irq_clear;
  logic ps_write;
  logic addr_ok;
  logic wr_q;
  logic [ADDR_W-1:0] addr_q;
  logic [31:0] rdata_q;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [crps_pkg::HALF_W-1:0] half_len;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator edge detect; the input is already synchronous
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= OSC_IN;
    end
  end

  assign osc_fall = osc_q && !OSC_IN;

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider; length follows the applied power-save setting
  assign half_len = crps_pkg::div_half(act_en_q, act_sel_q);
  assign release_force = (st_q == crps_pkg::ST_HELD) && osc_fall && EXTERNAL_INIT_N_IN
                         && clk_q;
  // Restart on realign, during a skipped beat and at each applied change
  assign div_restart = realign_q || release_force || (skip_q != 2'h0) || apply_now;

  crps_div #(
    .CNT_W(crps_pkg::HALF_W)
  ) u_div (
    .CLK_SYS_IN(CLK_SYS_IN),
    .RST_IN(RST_IN),
    .osc_fall_in(osc_fall),
    .restart_in(div_restart),
    .half_len_in(half_len),
    .toggle_out(toggle)
  );

  // Next clock level; toggles only on oscillator falls, never in a skip
  always_comb begin
    clk_d = clk_q;
    if (release_force) begin
      clk_d = 1'b0;
    end else if (toggle && (skip_q == 2'h0)) begin
      clk_d = !clk_q;
    end
  end

  assign clk_fall = clk_q && !clk_d;
  assign clk_edge = clk_q != clk_d;

  // Clock output register; divided clock drives every consumer at once
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= clk_d;
    end
  end

  // Skipped beat: held low for two oscillator cycles after release
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      skip_q <= 2'h0;
    end else if (release_force) begin
      skip_q <= crps_pkg::SKIP_LOAD;
    end else if (osc_fall && (skip_q != 2'h0)) begin
      skip_q <= skip_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer; the input is sampled on each oscillator fall
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_q <= crps_pkg::ST_HELD;
      sys_reset_q <= 1'b1;
      realign_q <= 1'b0;
      rel_q <= 2'h0;
    end else begin
      realign_q <= 1'b0;
      case (st_q)
        crps_pkg::ST_RUN: begin
          if (osc_fall && !EXTERNAL_INIT_N_IN) begin
            st_q <= crps_pkg::ST_ASSERT;
            realign_q <= 1'b1;
          end
        end
        crps_pkg::ST_ASSERT: begin
          if (osc_fall) begin
            if (!EXTERNAL_INIT_N_IN) begin
              st_q <= crps_pkg::ST_HELD;
              sys_reset_q <= 1'b1;
            end else begin
              st_q <= crps_pkg::ST_RUN;
            end
          end
        end
        crps_pkg::ST_HELD: begin
          if (osc_fall && EXTERNAL_INIT_N_IN) begin
            st_q <= crps_pkg::ST_RELEASE;
            // Forced low fall is the first of the two falls
            if (release_force) begin
              rel_q <= crps_pkg::RELEASE_FALLS - 2'h1;
            end else begin
              rel_q <= crps_pkg::RELEASE_FALLS;
            end
          end
        end
        crps_pkg::ST_RELEASE: begin
          if (osc_fall && !EXTERNAL_INIT_N_IN) begin
            st_q <= crps_pkg::ST_HELD;
            realign_q <= 1'b1;
          end else if (clk_fall) begin
            rel_q <= rel_q - 1'b1;
            if (rel_q == 2'h1) begin
              st_q <= crps_pkg::ST_RUN;
              sys_reset_q <= 1'b0;
            end
          end
        end
        default: begin
          st_q <= crps_pkg::ST_HELD;
          sys_reset_q <= 1'b1;
        end
      endcase
    end
  end

  // First bus cycle marker, thirteen clock half periods after release
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bus_cnt_q <= 4'h0;
      bus_start_q <= 1'b0;
    end else begin
      bus_start_q <= 1'b0;
      if ((st_q == crps_pkg::ST_HELD) && osc_fall && EXTERNAL_INIT_N_IN) begin
        // Forced low edge already spends the first half period
        if (release_force) begin
          bus_cnt_q <= crps_pkg::BUS_START_HALVES - 4'h1;
        end else begin
          bus_cnt_q <= crps_pkg::BUS_START_HALVES;
        end
      end else if (st_q == crps_pkg::ST_ASSERT || st_q == crps_pkg::ST_HELD) begin
        bus_cnt_q <= 4'h0;
      end else if (clk_edge && (bus_cnt_q != 4'h0)) begin
        bus_cnt_q <= bus_cnt_q - 1'b1;
        bus_start_q <= (bus_cnt_q == 4'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-save control register
  assign addr_ok = HSEL_IN && HTRANS_IN[1] && HREADY_IN && (HSIZE_IN == crps_pkg::HSIZE_WORD);
  assign ps_write = wr_q && (addr_q == ADDR_W'(crps_pkg::ADDR_PWR_SAVE));
  // Only NMI and interrupts that reach the core end power save
  assign irq_clear = (NMI_IN || IRQ_TO_CORE_IN) && ps_en_q;

  // Interrupt clear beats a same-cycle write; return never sets it
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ps_en_q <= crps_pkg::PWR_SAVE_RESET[crps_pkg::LOW_POWER_ENABLE_BIT];
      ps_sel_q <= crps_pkg::PWR_SAVE_RESET[crps_pkg::DIV_SEL_LSB +: crps_pkg::DIV_SEL_W];
    end else if (sys_reset_q) begin
      ps_en_q <= 1'b0;
      ps_sel_q <= crps_pkg::SEL_DIV1;
    end else begin
      if (ps_write) begin
        ps_sel_q <= HWDATA_IN[crps_pkg::DIV_SEL_LSB +: crps_pkg::DIV_SEL_W];
        ps_en_q <= HWDATA_IN[crps_pkg::LOW_POWER_ENABLE_BIT];
      end
      if (irq_clear) begin
        ps_en_q <= 1'b0;
      end
    end
  end

  // Change waits for the third falling clock edge, the third bus state
  assign apply_now = clk_fall && (pend_q == 2'h1);

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pend_q <= 2'h0;
    end else if (sys_reset_q) begin
      pend_q <= 2'h0;
    end else if (ps_write || irq_clear) begin
      pend_q <= crps_pkg::APPLY_FALLS;
    end else if (clk_fall && (pend_q != 2'h0)) begin
      pend_q <= pend_q - 1'b1;
    end
  end

  // Applied only on a falling clock edge, so the output never glitches
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      act_en_q <= 1'b0;
      act_sel_q <= crps_pkg::SEL_DIV1;
    end else if (sys_reset_q) begin
      act_en_q <= 1'b0;
      act_sel_q <= crps_pkg::SEL_DIV1;
    end else if (apply_now) begin
      act_en_q <= ps_en_q;
      act_sel_q <= ps_sel_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wr_q <= 1'b0;
      addr_q <= '0;
    end else begin
      wr_q <= addr_ok && HWRITE_IN;
      addr_q <= HADDR_IN;
    end
  end

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[crps_pkg::LOW_POWER_ENABLE_BIT] = ps_en_q;
    ctrl_word[crps_pkg::DIV_SEL_LSB +: crps_pkg::DIV_SEL_W] = ps_sel_q;
    status_word = 32'h0000_0000;
    status_word[crps_pkg::STAT_STATE_LSB +: 2] = st_q;
    status_word[crps_pkg::STAT_RESET_BIT] = sys_reset_q;
    status_word[crps_pkg::STAT_PEND_BIT] = pend_q != 2'h0;
    status_word[crps_pkg::STAT_ACT_SEL_LSB +: 2] = act_sel_q;
    status_word[crps_pkg::STAT_ACT_EN_BIT] = act_en_q;
  end

  // Read data captured in the address phase; unmapped reads give zero
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ok && !HWRITE_IN) begin
      if (HADDR_IN == ADDR_W'(crps_pkg::ADDR_PWR_SAVE)) begin
        rdata_q <= ctrl_word;
      end else if (HADDR_IN == ADDR_W'(crps_pkg::ADDR_STATUS)) begin
        rdata_q <= status_word;
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign HRDATA_OUT = rdata_q;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = crps_pkg::HRESP_OKAY;
  assign CLOCK_OUT = clk_q;
  assign SYS_RESET_OUT = sys_reset_q;
  assign PHASE_REALIGN_PULSE_OUT = realign_q;
  assign BUS_GRANT_ACK_OUT = sys_reset_q && HOLD_REQ_IN;
  assign PREFETCH_EN_OUT = !sys_reset_q;
  assign BUS_START_OUT = bus_start_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  sequence s_release_seen;
    (st_q == crps_pkg::ST_HELD) && osc_fall && EXTERNAL_INIT_N_IN;
  endsequence

  sequence s_assert_twice;
    (st_q == crps_pkg::ST_ASSERT) && osc_fall && !EXTERNAL_INIT_N_IN;
  endsequence

  a_clock_osc_fall: assert property (!$stable(clk_q) |-> $past(osc_fall))
    else $error("clock output changed without an oscillator fall");

  a_warm_reset_two: assert property (s_assert_twice |=> sys_reset_q && !PREFETCH_EN_OUT)
    else $error("internal reset not taken on second oscillator fall");

  a_realign_one_cycle: assert property (
    realign_q |-> !$past(realign_q) && (st_q != crps_pkg::ST_RUN) ##1 !realign_q)
    else $error("realign pulse wrong length or state");

  a_skip_beat_low: assert property (s_release_seen ##0 clk_q |=> !clk_q [*2])
    else $error("clock not held low after release sample");

  a_no_skip_low: assert property (s_release_seen ##0 !clk_q |=> skip_q == 2'h0)
    else $error("correction made while clock already low");

  a_release_falls: assert property (
    (st_q == crps_pkg::ST_RELEASE) && clk_fall && (rel_q == 2'h1) && EXTERNAL_INIT_N_IN
    |=> !sys_reset_q && (st_q == crps_pkg::ST_RUN))
    else $error("internal reset not released on second clock fall");

  a_bus_start_halves: assert property (
    s_release_seen
    |=> (bus_cnt_q == crps_pkg::BUS_START_HALVES - ($past(clk_q) ? 4'h1 : 4'h0)))
    else $error("bus start count not loaded at release");

  a_grant_in_reset: assert property (
    sys_reset_q && HOLD_REQ_IN |-> BUS_GRANT_ACK_OUT && !PREFETCH_EN_OUT)
    else $error("hold not granted at once during reset");

  a_half_period_len: assert property (
    toggle && (skip_q == 2'h0) && !release_force
    |-> u_div.cnt_q == crps_pkg::HALF_W'(crps_pkg::div_half(act_en_q, act_sel_q) - 1'b1))
    else $error("clock half period length does not match divisor");

  a_irq_clears_enable: assert property (
    irq_clear |=> !ps_en_q && (pend_q == crps_pkg::APPLY_FALLS || sys_reset_q))
    else $error("interrupt did not clear power save");

  a_apply_on_fall: assert property (
    !$stable(act_sel_q) && !$past(sys_reset_q) |-> $past(clk_fall) && !clk_q)
    else $error("divisor applied away from a falling clock edge");

endmodule

// >>> test/crps_ext_model.sv
`timescale 1ns/100ps
module crps_ext_model #(
  parameter int unsigned MIN_LOW_FALLS = 40
) (
  input wire logic clk_in,
  input wire logic reset_req_in,
  input wire logic hold_want_in,
  output logic osc_out,
  output logic init_n_out,
  output logic hold_req_out
);
  logic phase_q = 1'b0;
  logic osc_q = 1'b1;
  logic init_n_q = 1'b0;
  logic hold_q = 1'b0;
  logic [7:0] low_cnt_q = 8'h00;

  assign osc_out = osc_q;
  assign init_n_out = init_n_q;
  assign hold_req_out = hold_q;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator runs free, half period of two system cycles
  always @(posedge clk_in) begin
    phase_q <= ~phase_q;
    if (phase_q) begin
      osc_q <= ~osc_q;
    end
  end

  // Reset source moves only at an oscillator rise, so the sample is clean
  always @(posedge clk_in) begin
    hold_q <= hold_want_in;
    if (phase_q && osc_q && !init_n_q && low_cnt_q != 8'hff) begin
      low_cnt_q <= low_cnt_q + 8'h01; // Falls seen while held low
    end
    if (phase_q && !osc_q) begin
      if (reset_req_in && init_n_q) begin
        init_n_q <= 1'b0;
        low_cnt_q <= 8'h00;
      end else if (!reset_req_in && 32'(low_cnt_q) >= MIN_LOW_FALLS) begin
        init_n_q <= 1'b1;
      end
    end
  end
endmodule

// >>> test/tb_clock_reset_power_save.sv
`timescale 1ns/100ps
module tb_clock_reset_power_save;
  logic clk, rst, nmi, irq, hsel, hwrite, rst_req, hold_want, c;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, rd;
  wire logic osc, init_n, hold_req, hready, hresp, clk_out, sys_rst;
  wire logic realign, grant, prefetch, bus_start;
  wire logic [31:0] hrdata;
  int fails = 0;
  int total_checks = 0;
  int n, f, e, rf, ef, osc_f;
  logic po;
  int div_tab[4] = '{1, 4, 8, 16};

  crps_ext_model ext (.clk_in(clk), .reset_req_in(rst_req), .hold_want_in(hold_want),
    .osc_out(osc), .init_n_out(init_n), .hold_req_out(hold_req));

  crps_top dut (.CLK_SYS_IN(clk), .RST_IN(rst), .OSC_IN(osc), .EXTERNAL_INIT_N_IN(init_n),
    .HOLD_REQ_IN(hold_req), .NMI_IN(nmi), .IRQ_TO_CORE_IN(irq), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
    .HRESP_OUT(hresp), .CLOCK_OUT(clk_out), .SYS_RESET_OUT(sys_rst),
    .PHASE_REALIGN_PULSE_OUT(realign), .BUS_GRANT_ACK_OUT(grant),
    .PREFETCH_EN_OUT(prefetch), .BUS_START_OUT(bus_start));

  ////////////////////////////////////////////////////////////////////////////
  // System clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  // Waits for k falling edges of the processor clock
  task automatic clk_falls(input int k);
    repeat (k) begin
      @(negedge clk);
      while (clk_out !== 1'b1) @(negedge clk);
      while (clk_out !== 1'b0) @(negedge clk);
    end
  endtask

  // Both halves of one clock period, in system cycles
  task automatic halves(input int exp_len);
    @(negedge clk);
    c = clk_out;
    while (clk_out === c) @(negedge clk);
    repeat (2) begin
      c = clk_out;
      n = 0;
      while (clk_out === c && n < 200) begin
        @(negedge clk);
        n++;
      end
      check("clock half period", exp_len, n);
    end
  endtask

  // Counts clock edges from the release until the first bus cycle
  task automatic release_run();
    @(posedge clk);
    rst_req <= 1'b0;
    while (init_n !== 1'b1) @(negedge clk);
    c = clk_out;
    po = osc;
    // Release with the clock high skips one beat, so one edge fewer
    ef = (c === 1'b1) ? 13 : 14;
    f = 0;
    e = 0;
    n = 0;
    osc_f = 0;
    rf = -1;
    while (bus_start !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
      osc_f += (po === 1'b1 && osc === 1'b0);
      po = osc;
      if (clk_out !== c) begin
        e++;
        f += (c === 1'b1);
        c = clk_out;
      end
      if (sys_rst === 1'b0 && rf < 0) rf = f;
    end
    check("clock falls to reset release", 2, rf);
    check("clock edges to first bus cycle", ef, e);
    // Sampling fall plus thirteen undivided half periods
    check("oscillator falls to first bus cycle", 14, osc_f);
    check("prefetch after release", 1, prefetch);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, well beyond the expected run
  initial begin
    #160000;
    fails++;
    $display("mismatch watchdog expected finish seen timeout");
    print_verdict();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    nmi = 1'b0;
    irq = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 8'h00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rst_req = 1'b1;
    hold_want = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (112) @(posedge clk);
    @(negedge clk);
    check("reset during cold start", 1, sys_rst);
    check("prefetch in reset", 0, prefetch);
    check("grant in reset", 1, grant);
    halves(4);
    bus(1'b1, 8'h00, 32'h8001);
    bus(1'b0, 8'h00, 32'h0);
    check("control in reset", 32'h0, rd);
    check("response", 0, hresp);
    release_run();
    check("grant after reset", 0, grant);
    hold_want <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 8'h00, 32'h8000 | s);
      bus(1'b0, 8'h00, 32'h0);
      check("control readback", 32'h8000 | s, rd);
      clk_falls(4);
      halves(4 * div_tab[s]);
      bus(1'b0, 8'h04, 32'h0);
      check("applied setting", 32'h8000 | (s << 12), rd);
    end
    bus(1'b1, 8'h00, 32'hffffffff);
    bus(1'b0, 8'h00, 32'h0);
    check("reserved bits", 32'h8003, rd);
    bus(1'b1, 8'h00, 32'h0003);
    clk_falls(4);
    halves(4);
    bus(1'b0, 8'h08, 32'h0);
    check("unmapped read", 32'h0, rd);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 8'h00, 32'h8002);
      clk_falls(4);
      halves(32);
      @(posedge clk);
      nmi <= (i == 0);
      irq <= (i == 1);
      @(posedge clk);
      nmi <= 1'b0;
      irq <= 1'b0;
      bus(1'b0, 8'h00, 32'h0);
      check("control after interrupt", 32'h0002, rd);
      clk_falls(4);
      halves(4);
    end
    @(posedge clk);
    rst_req <= 1'b1;
    n = 0;
    while (realign !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check("realign pulse", 1, realign);
    c = osc;
    f = 0;
    while (sys_rst !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
      f += (c === 1'b1 && osc === 1'b0);
      c = osc;
    end
    check("oscillator falls to warm reset", 1, f);
    bus(1'b0, 8'h00, 32'h0);
    check("control after warm reset", 32'h0, rd);
    release_run();
    print_verdict();
  end
endmodule
